// ---- logic/complementary_output_timing.sv ----
// Output steering and event timing of a four-output complementary
// generator, with an APB register slave.
// Assumes rise and fall events and the mode field synchronous to sys_clk.
//
// Contract
// [R1] Unrouted output drives its fixed level bit
// [R2] Routed output drives waveform with polarity inversion
// [R3] Steering honoured only when mode field 00x
// [R4] Rise dead-band counts clocks when source 0
// [R5] Rise dead-band counts chain elements when source 1
// [R6] Fall dead-band counts clocks when source 0
// [R7] Fall dead-band counts chain elements when source 1
// [R8] Rise blanking ignores fall events for count
// [R9] Fall blanking ignores rise events for count
// [R10] Rise events postponed by phase delay count
// [R11] Count registers read bits 7-6 as zero
// [R12] Rise blanking keeps value; others clear on reset
// [R13] Zero count adds no delay or blanking
`include "cog_timing_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module complementary_output_timing #(
  parameter int CHAIN_DIV = `CT_CHAIN_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Generator side
  input wire logic riseEvent,
  input wire logic fallEvent,
  input wire logic [2:0] generatorModeField,
  // Output pins
  output logic driveOutputA,
  output logic driveOutputB,
  output logic driveOutputC,
  output logic driveOutputD
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CHAIN_DIV < 1 || CHAIN_DIV > 255) begin : g_bad_div
    $error("CHAIN_DIV must lie in 1..255");
  end

  localparam cog_timing_pkg::chain_t CHAIN_LAST =
    cog_timing_pkg::chain_t'(CHAIN_DIV - 1);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `CT_OFS_STEER) || (a == `CT_OFS_RISE_DB) ||
      (a == `CT_OFS_FALL_DB) || (a == `CT_OFS_RISE_BLK) ||
      (a == `CT_OFS_FALL_BLK) || (a == `CT_OFS_RISE_PH) ||
      (a == `CT_OFS_CTL) || (a == `CT_OFS_STATUS);
  endfunction

  function automatic logic isCount(input logic [7:0] a);
    isCount = (a == `CT_OFS_RISE_DB) || (a == `CT_OFS_FALL_DB) ||
      (a == `CT_OFS_RISE_BLK) || (a == `CT_OFS_FALL_BLK) ||
      (a == `CT_OFS_RISE_PH);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] steer_ff, nxt_steer;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [7:0] status;
  cog_timing_pkg::count_t riseDeadbandValue_ff, nxt_riseDeadbandValue;
  cog_timing_pkg::count_t fallDeadbandValue_ff, nxt_fallDeadbandValue;
  cog_timing_pkg::count_t riseBlankingValue_ff, nxt_riseBlankingValue;
  cog_timing_pkg::count_t fallBlankingValue_ff, nxt_fallBlankingValue;
  cog_timing_pkg::count_t risePhaseValue_ff, nxt_risePhaseValue;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  cog_timing_pkg::chain_t chainCnt_ff, nxt_chainCnt;
  logic chainTick;
  logic phaseRun_ff, nxt_phaseRun;
  cog_timing_pkg::count_t phaseCnt_ff, nxt_phaseCnt;
  logic riseFire_ff, nxt_riseFire;
  logic wave_ff, nxt_wave;
  logic primary_ff, nxt_primary;
  logic compl_ff, nxt_compl;
  logic riseDbRun_ff, nxt_riseDbRun;
  logic fallDbRun_ff, nxt_fallDbRun;
  cog_timing_pkg::count_t riseDbCnt_ff, nxt_riseDbCnt;
  cog_timing_pkg::count_t fallDbCnt_ff, nxt_fallDbCnt;
  cog_timing_pkg::count_t riseBlkCnt_ff, nxt_riseBlkCnt;
  cog_timing_pkg::count_t fallBlkCnt_ff, nxt_fallBlkCnt;
  logic [3:0] drive_ff, nxt_drive;
  logic [3:0] waveBus;
  logic steerOn;
  logic setup, access, wrEn;
  logic riseAccept, fallAccept, tickRise, tickFall;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle so prdata is a flop output;
  // the cost is nothing, the access phase never waits.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wrEn = access && pwrite && isMapped(paddr);
  assign pready = access;
  assign pslverr = access && err_ff;
  assign prdata = rdata_ff;

  assign status = {drive_ff, compl_ff, primary_ff, phaseRun_ff, wave_ff};

  always_comb begin
    nxt_steer = steer_ff;
    nxt_ctl = ctl_ff;
    nxt_riseDeadbandValue = riseDeadbandValue_ff;
    nxt_fallDeadbandValue = fallDeadbandValue_ff;
    nxt_riseBlankingValue = riseBlankingValue_ff;
    nxt_fallBlankingValue = fallBlankingValue_ff;
    nxt_risePhaseValue = risePhaseValue_ff;
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = !isMapped(paddr);
      nxt_rdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `CT_OFS_STEER: nxt_rdata[7:0] = steer_ff;
          `CT_OFS_RISE_DB: nxt_rdata[5:0] = riseDeadbandValue_ff; // [R11]
          `CT_OFS_FALL_DB: nxt_rdata[5:0] = fallDeadbandValue_ff; // [R11]
          `CT_OFS_RISE_BLK: nxt_rdata[5:0] = riseBlankingValue_ff; // [R11]
          `CT_OFS_FALL_BLK: nxt_rdata[5:0] = fallBlankingValue_ff; // [R11]
          `CT_OFS_RISE_PH: nxt_rdata[5:0] = risePhaseValue_ff; // [R11]
          `CT_OFS_CTL: nxt_rdata[7:0] = ctl_ff;
          `CT_OFS_STATUS: nxt_rdata[7:0] = status;
          default: nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wrEn) begin
      case (paddr)
        `CT_OFS_STEER: nxt_steer = pwdata[7:0];
        `CT_OFS_RISE_DB: nxt_riseDeadbandValue = pwdata[5:0];
        `CT_OFS_FALL_DB: nxt_fallDeadbandValue = pwdata[5:0];
        `CT_OFS_RISE_BLK: nxt_riseBlankingValue = pwdata[5:0];
        `CT_OFS_FALL_BLK: nxt_fallBlankingValue = pwdata[5:0];
        `CT_OFS_RISE_PH: nxt_risePhaseValue = pwdata[5:0];
        `CT_OFS_CTL: nxt_ctl = pwdata[7:0] & 8'hCF;
        default: nxt_ctl = ctl_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      steer_ff <= `CT_RST_STEER; // [R12]
      ctl_ff <= `CT_RST_CTL;
      riseDeadbandValue_ff <= `CT_RST_COUNT; // [R12]
      fallDeadbandValue_ff <= `CT_RST_COUNT; // [R12]
      fallBlankingValue_ff <= `CT_RST_COUNT; // [R12]
      risePhaseValue_ff <= `CT_RST_COUNT; // [R12]
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      steer_ff <= nxt_steer;
      ctl_ff <= nxt_ctl;
      riseDeadbandValue_ff <= nxt_riseDeadbandValue;
      fallDeadbandValue_ff <= nxt_fallDeadbandValue;
      fallBlankingValue_ff <= nxt_fallBlankingValue;
      risePhaseValue_ff <= nxt_risePhaseValue;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  // Rise blanking survives reset; it is unknown only until first written
  always_ff @(posedge sys_clk) begin
    riseBlankingValue_ff <= nxt_riseBlankingValue; // [R12]
  end

  // ----------------------------------------------------------------
  // Delay chain time base
  // ----------------------------------------------------------------
  // The analog chain is modelled as a clock divider; one element period
  // is CHAIN_DIV clocks, so resolution is coarser than the real chain.
  assign chainTick = (chainCnt_ff == CHAIN_LAST);

  always_comb begin
    nxt_chainCnt = chainTick ? 8'h00 : chainCnt_ff + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chainCnt_ff <= 8'h00;
    end else begin
      chainCnt_ff <= nxt_chainCnt;
    end
  end

  // ----------------------------------------------------------------
  // Event timing
  // ----------------------------------------------------------------
  assign tickRise = ctl_ff[`CT_CTL_RISE_SRC] ? chainTick : 1'b1; // [R4] [R5]
  assign tickFall = ctl_ff[`CT_CTL_FALL_SRC] ? chainTick : 1'b1; // [R6] [R7]
  // A rise already being phase delayed absorbs further rises
  assign riseAccept = riseEvent && (fallBlkCnt_ff == 6'h00) && // [R9]
    !phaseRun_ff;
  // A fall coinciding with a rise firing loses to the rise
  assign fallAccept = fallEvent && (riseBlkCnt_ff == 6'h00) && // [R8]
    !riseFire_ff;

  always_comb begin
    nxt_phaseRun = phaseRun_ff;
    nxt_phaseCnt = phaseCnt_ff;
    nxt_riseFire = 1'b0;
    if (riseAccept) begin
      if (risePhaseValue_ff == 6'h00) begin
        nxt_riseFire = 1'b1; // [R13]
      end else begin
        nxt_phaseRun = 1'b1; // [R10]
        nxt_phaseCnt = risePhaseValue_ff;
      end
    end else if (phaseRun_ff) begin
      nxt_phaseCnt = phaseCnt_ff - 6'h01; // [R10]
      if (phaseCnt_ff == 6'h01) begin
        nxt_riseFire = 1'b1;
        nxt_phaseRun = 1'b0;
      end
    end

    nxt_wave = wave_ff;
    nxt_primary = primary_ff;
    nxt_compl = compl_ff;
    nxt_riseDbRun = riseDbRun_ff;
    nxt_fallDbRun = fallDbRun_ff;
    nxt_riseDbCnt = riseDbCnt_ff;
    nxt_fallDbCnt = fallDbCnt_ff;
    nxt_riseBlkCnt = riseBlkCnt_ff;
    nxt_fallBlkCnt = fallBlkCnt_ff;
    if (riseBlkCnt_ff != 6'h00) begin
      nxt_riseBlkCnt = riseBlkCnt_ff - 6'h01; // [R8]
    end
    if (fallBlkCnt_ff != 6'h00) begin
      nxt_fallBlkCnt = fallBlkCnt_ff - 6'h01; // [R9]
    end
    if (riseDbRun_ff && tickRise) begin
      nxt_riseDbCnt = riseDbCnt_ff - 6'h01; // [R4] [R5]
      if (riseDbCnt_ff == 6'h01) begin
        nxt_primary = 1'b1;
        nxt_riseDbRun = 1'b0;
      end
    end
    if (fallDbRun_ff && tickFall) begin
      nxt_fallDbCnt = fallDbCnt_ff - 6'h01; // [R6] [R7]
      if (fallDbCnt_ff == 6'h01) begin
        nxt_compl = 1'b1;
        nxt_fallDbRun = 1'b0;
      end
    end
    if (riseFire_ff) begin
      nxt_wave = 1'b1;
      nxt_compl = 1'b0;
      nxt_fallDbRun = 1'b0;
      nxt_riseBlkCnt = riseBlankingValue_ff; // [R8]
      if (riseDeadbandValue_ff == 6'h00) begin
        nxt_primary = 1'b1; // [R13]
      end else begin
        nxt_riseDbRun = 1'b1; // [R4] [R5]
        nxt_riseDbCnt = riseDeadbandValue_ff;
      end
    end else if (fallAccept) begin
      nxt_wave = 1'b0;
      nxt_primary = 1'b0;
      nxt_riseDbRun = 1'b0;
      nxt_fallBlkCnt = fallBlankingValue_ff; // [R9]
      if (fallDeadbandValue_ff == 6'h00) begin
        nxt_compl = 1'b1; // [R13]
      end else begin
        nxt_fallDbRun = 1'b1; // [R6] [R7]
        nxt_fallDbCnt = fallDeadbandValue_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseRun_ff <= 1'b0;
      phaseCnt_ff <= `CT_RST_COUNT;
      riseFire_ff <= 1'b0;
      wave_ff <= 1'b0;
      primary_ff <= 1'b0;
      compl_ff <= 1'b0;
      riseDbRun_ff <= 1'b0;
      fallDbRun_ff <= 1'b0;
      riseDbCnt_ff <= `CT_RST_COUNT;
      fallDbCnt_ff <= `CT_RST_COUNT;
      riseBlkCnt_ff <= `CT_RST_COUNT;
      fallBlkCnt_ff <= `CT_RST_COUNT;
    end else begin
      phaseRun_ff <= nxt_phaseRun;
      phaseCnt_ff <= nxt_phaseCnt;
      riseFire_ff <= nxt_riseFire;
      wave_ff <= nxt_wave;
      primary_ff <= nxt_primary;
      compl_ff <= nxt_compl;
      riseDbRun_ff <= nxt_riseDbRun;
      fallDbRun_ff <= nxt_fallDbRun;
      riseDbCnt_ff <= nxt_riseDbCnt;
      fallDbCnt_ff <= nxt_fallDbCnt;
      riseBlkCnt_ff <= nxt_riseBlkCnt;
      fallBlkCnt_ff <= nxt_fallBlkCnt;
    end
  end

  // ----------------------------------------------------------------
  // Output steering
  // ----------------------------------------------------------------
  assign steerOn = (generatorModeField[2:1] == 2'b00); // [R3]
  assign waveBus = {compl_ff, primary_ff, compl_ff, primary_ff};

  for (genvar i = 0; i < 4; i++) begin : g_steer
    assign nxt_drive[i] = (steerOn && !steer_ff[i]) ?
      steer_ff[i + `CT_STEER_FIXED_LSB] : // [R1]
      (waveBus[i] ^ ctl_ff[i]); // [R2]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_ff <= 4'h0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign driveOutputA = drive_ff[0];
  assign driveOutputB = drive_ff[1];
  assign driveOutputC = drive_ff[2];
  assign driveOutputD = drive_ff[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  cog_timing_pkg::age_t riseAge_ff, fallAge_ff, acceptAge_ff;
  logic afterReset_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      riseAge_ff <= `CT_RST_AGE;
      fallAge_ff <= `CT_RST_AGE;
      acceptAge_ff <= `CT_RST_AGE;
      afterReset_ff <= 1'b1;
    end else begin
      riseAge_ff <= riseFire_ff ? 8'h01 :
        ((riseAge_ff == 8'hFF) ? riseAge_ff : riseAge_ff + 8'h01);
      fallAge_ff <= fallAccept ? 8'h01 :
        ((fallAge_ff == 8'hFF) ? fallAge_ff : fallAge_ff + 8'h01);
      acceptAge_ff <= riseAccept ? 8'h01 :
        ((acceptAge_ff == 8'hFF) ? acceptAge_ff : acceptAge_ff + 8'h01);
      afterReset_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_static_level;
    (steerOn && !steer_ff[0]) |=> (driveOutputA == $past(steer_ff[4]));
  endproperty
  a_static_level: assert property (p_static_level) // [R1]
    else $error("static level not driven");

  property p_routed_wave;
    (steerOn && steer_ff[1]) |=> (driveOutputB == $past(compl_ff ^ ctl_ff[1]));
  endproperty
  a_routed_wave: assert property (p_routed_wave) // [R2]
    else $error("routed waveform wrong");

  property p_mode_ignores;
    !steerOn |=> (driveOutputC == $past(primary_ff ^ ctl_ff[2]));
  endproperty
  a_mode_ignores: assert property (p_mode_ignores) // [R3]
    else $error("steering honoured outside mode 00x");

  property p_rise_db_clock;
    ($rose(primary_ff) && !ctl_ff[`CT_CTL_RISE_SRC]) |->
      (riseAge_ff == {2'b00, riseDeadbandValue_ff} + 8'h01);
  endproperty
  a_rise_db_clock: assert property (p_rise_db_clock) // [R4]
    else $error("rise dead-band clock count wrong");

  property p_rise_db_chain;
    ($rose(primary_ff) && ctl_ff[`CT_CTL_RISE_SRC] &&
      riseDeadbandValue_ff != 6'h00) |->
      ($past(chainTick) && riseAge_ff > {2'b00, riseDeadbandValue_ff});
  endproperty
  a_rise_db_chain: assert property (p_rise_db_chain) // [R5]
    else $error("rise dead-band chain timing wrong");

  property p_fall_db_clock;
    ($rose(compl_ff) && !ctl_ff[`CT_CTL_FALL_SRC]) |->
      (fallAge_ff == {2'b00, fallDeadbandValue_ff} + 8'h01);
  endproperty
  a_fall_db_clock: assert property (p_fall_db_clock) // [R6]
    else $error("fall dead-band clock count wrong");

  property p_fall_db_chain;
    ($rose(compl_ff) && ctl_ff[`CT_CTL_FALL_SRC] &&
      fallDeadbandValue_ff != 6'h00) |->
      ($past(chainTick) && fallAge_ff > {2'b00, fallDeadbandValue_ff});
  endproperty
  a_fall_db_chain: assert property (p_fall_db_chain) // [R7]
    else $error("fall dead-band chain timing wrong");

  property p_rise_blank;
    $fell(wave_ff) |-> (riseAge_ff > {2'b00, riseBlankingValue_ff} + 8'h01);
  endproperty
  a_rise_blank: assert property (p_rise_blank) // [R8]
    else $error("fall event passed rise blanking");

  property p_fall_blank;
    riseFire_ff |-> (fallAge_ff > {2'b00, fallBlankingValue_ff} + 8'h01);
  endproperty
  a_fall_blank: assert property (p_fall_blank) // [R9]
    else $error("rise event passed fall blanking");

  property p_phase;
    riseFire_ff |-> (acceptAge_ff == {2'b00, risePhaseValue_ff} + 8'h01);
  endproperty
  a_phase: assert property (p_phase) // [R10]
    else $error("rise phase delay wrong");

  property p_upper_zero;
    (setup && !pwrite && isCount(paddr)) |=> (prdata[31:6] == 26'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) // [R11]
    else $error("unimplemented count bits read non-zero");

  property p_reset_values;
    afterReset_ff |-> (steer_ff == 8'h00 && riseDeadbandValue_ff == 6'h00 &&
      fallBlankingValue_ff == 6'h00 && risePhaseValue_ff == 6'h00);
  endproperty
  a_reset_values: assert property (p_reset_values) // [R12]
    else $error("register not cleared by reset");

  property p_zero_db;
    (riseFire_ff && riseDeadbandValue_ff == 6'h00) |=> primary_ff;
  endproperty
  a_zero_db: assert property (p_zero_db) // [R13]
    else $error("zero dead-band added delay");

  c_rise: cover property (riseFire_ff ##[1:80] $rose(primary_ff));
  c_fall: cover property (fallAccept ##[1:80] $rose(compl_ff));
  c_static: cover property (steerOn && !steer_ff[3] && steer_ff[7]);
  c_blanked: cover property (fallEvent && riseBlkCnt_ff != 6'h00);

endmodule

`default_nettype wire

// ---- common/cog_timing_regs.svh ----
// Register map, field positions, reset values and counts of the
// complementary output timing block.
// Assumes a byte-addressed APB slave with one 32-bit word per register.
`ifndef COG_TIMING_REGS_SVH
`define COG_TIMING_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CT_OFS_STEER 8'h00
`define CT_OFS_RISE_DB 8'h04
`define CT_OFS_FALL_DB 8'h08
`define CT_OFS_RISE_BLK 8'h0C
`define CT_OFS_FALL_BLK 8'h10
`define CT_OFS_RISE_PH 8'h14
`define CT_OFS_CTL 8'h18
`define CT_OFS_STATUS 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CT_STEER_FIXED_LSB 4
`define CT_CTL_RISE_SRC 7
`define CT_CTL_FALL_SRC 6
`define CT_STAT_WAVE 0
`define CT_STAT_PHASE 1
`define CT_STAT_PRIMARY 2
`define CT_STAT_COMPL 3
`define CT_STAT_DRIVE_LSB 4

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CT_RST_STEER 8'h00
`define CT_RST_COUNT 6'h00
`define CT_RST_CTL 8'h00
`define CT_RST_AGE 8'hFF
`define CT_CHAIN_DIV_DEFAULT 2

`endif

// ---- common/cog_timing_pkg.sv ----
// Types shared by the complementary output timing block.
// Assumes nothing of its surroundings.
package cog_timing_pkg;
  typedef logic [5:0] count_t;
  typedef logic [7:0] age_t;
  typedef logic [7:0] chain_t;
endpackage

// ---- test/power_stage_model.sv ----
// Power stage model: the switch drivers behind the four output pins.
// Assumes pins registered on the rising edge of sys_clk.
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Switch drive pins, D..A
  input wire logic [3:0] drivePins,
  // Observed gate state
  output logic [3:0] legsSeen,
  output logic legsMoved
);
  // ----------------------------------------------------------------
  // Gate sampling
  // ----------------------------------------------------------------
  // Sampled mid-cycle so the bench reads settled levels, never a race
  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      legsSeen <= 4'h0;
      legsMoved <= 1'b0;
    end else begin
      legsMoved <= (drivePins !== legsSeen);
      legsSeen <= drivePins;
    end
  end
endmodule
`default_nettype wire

// ---- test/complementary_output_timing_tb_top.sv ----
// Testbench: APB and event stimulus, predicted pins and read data.
// Assumes the hand-over timing and the power stage model.
`timescale 1ns/10ps
`default_nettype none
`include "cog_timing_regs.svh"
module complementary_output_timing_tb_top;
  // ----------------------------------------------------------------
  // Signals and expectation notes
  // ----------------------------------------------------------------
  localparam int CD = 3;
  typedef struct {logic [31:0] d; logic e;} rd_t;
  typedef struct {int lo; int hi; logic [3:0] p;} pin_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic riseEvent = 1'b0;
  logic fallEvent = 1'b0;
  logic [2:0] mode = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, legsMoved;
  wire [3:0] pins, legs;
  logic [3:0] lastP = 4'h0;
  logic [3:0] invM = 4'h0;
  logic [7:0] steerM = 8'h00;
  logic [31:0] seed = 32'h53;
  logic prim = 1'b0, comp = 1'b0, chainR = 1'b0, chainF = 1'b0;
  int num_errors = 0, checked = 0, cnt = 0, dbr = 0, dbf = 0, phr = 0;
  rd_t readQ[$];
  pin_t pinQ[$];

  complementary_output_timing #(.CHAIN_DIV(CD)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .riseEvent(riseEvent),
    .fallEvent(fallEvent), .generatorModeField(mode),
    .driveOutputA(pins[0]), .driveOutputB(pins[1]),
    .driveOutputC(pins[2]), .driveOutputD(pins[3]));
  power_stage_model psm (.sys_clk(sys_clk), .rst_n(rst_n),
    .drivePins(pins), .legsSeen(legs), .legsMoved(legsMoved));

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cnt <= cnt + 1;
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // A,C follow the primary wave, B,D the complementary one
  function automatic logic [3:0] pinsOf();
    logic [3:0] p;
    logic hon, w;
    hon = (mode[2:1] == 2'b00);
    for (int i = 0; i < 4; i++) begin
      w = ((i % 2) ? comp : prim) ^ invM[i];
      p[i] = (steerM[i] || !hon) ? w : steerM[4 + i];
    end
    return p;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, want, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Notes a pin change only when the predicted level really moves
  task automatic note(input int lo, input int hi);
    logic [3:0] p;
    p = pinsOf();
    if (p !== lastP) pinQ.push_back('{lo, hi, p});
    lastP = p;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      num_errors++;
      end_of_test();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      `CT_OFS_STEER: steerM = d[7:0];
      `CT_OFS_RISE_DB: dbr = d[5:0];
      `CT_OFS_FALL_DB: dbf = d[5:0];
      `CT_OFS_RISE_PH: phr = d[5:0];
      `CT_OFS_CTL: begin
        {chainR, chainF} = d[7:6];
        invM = d[3:0];
      end
      default: ;
    endcase
    note(cnt, cnt + 6);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic e);
    readQ.push_back('{d, e});
    apb(1'b0, a, 32'h0);
  endtask

  // One event pulse; when taken, predicts both pin moves
  task automatic ev(input logic r, input logic take);
    int b, t, n, lo, hi;
    @(posedge sys_clk);
    if (r) riseEvent <= 1'b1;
    else fallEvent <= 1'b1;
    b = cnt;
    @(posedge sys_clk);
    riseEvent <= 1'b0;
    fallEvent <= 1'b0;
    if (take) begin
      t = r ? b + 4 + phr : b + 3;
      n = r ? dbr : dbf;
      lo = t + n;
      hi = lo;
      // Chain timing is only bounded, its tick phase is free
      if (r ? chainR : chainF) begin
        lo = t + CD * (n - 1);
        hi = t + CD * (n + 1) + 2;
      end
      if (r) comp = 1'b0;
      else prim = 1'b0;
      if (n != 0) note(t, t);
      if (r) prim = 1'b1;
      else comp = 1'b1;
      note(lo, hi);
    end
  endtask

  task automatic pair(input int n);
    ev(1'b1, 1'b1);
    idle(n);
    ev(1'b0, 1'b1);
    idle(n);
  endtask

  task automatic reset_pulse();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    dbr = 0;
    dbf = 0;
    phr = 0;
  endtask

  // ----------------------------------------------------------------
  // Watcher
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    rd_t r;
    pin_t q;
    logic ok;
    if (psel && penable && pready && !pwrite) begin
      if (readQ.size() == 0) check("read note", 32'h1, 32'h0);
      else begin
        r = readQ.pop_front();
        check("prdata", prdata, r.d);
        check("pslverr", {31'h0, pslverr}, {31'h0, r.e});
      end
    end
    if (legsMoved === 1'b1) begin
      if (pinQ.size() == 0) check("pin change", 32'h1, 32'h0);
      else begin
        q = pinQ.pop_front();
        ok = (cnt >= q.lo) && (cnt <= q.hi);
        check("pin time", 32'(ok), 32'h1);
        check("pins", {28'h0, legs}, {28'h0, q.p});
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [5:0] keep;
    logic [7:0] ofs [5];
    ofs = '{`CT_OFS_RISE_DB, `CT_OFS_FALL_DB, `CT_OFS_RISE_BLK,
            `CT_OFS_FALL_BLK, `CT_OFS_RISE_PH};
    keep = 6'h00;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`CT_OFS_STEER, 32'h0, 1'b0);
    foreach (ofs[j]) if (j != 2) rd(ofs[j], 32'h0, 1'b0);
    rd(`CT_OFS_CTL, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    foreach (ofs[j]) begin
      v = rnd();
      wr(ofs[j], {24'h0, v[7:0] | 8'hC0});
      rd(ofs[j], {26'h0, v[5:0]}, 1'b0);
      if (j == 2) keep = v[5:0];
    end
    reset_pulse();
    v = {26'h0, keep};
    foreach (ofs[j]) rd(ofs[j], (j == 2) ? v : 32'h0, 1'b0);
    wr(`CT_OFS_RISE_BLK, 32'h0);
    ev(1'b0, 1'b1);
    wr(`CT_OFS_STEER, 32'h50);
    wr(`CT_OFS_STEER, 32'h0F);
    wr(`CT_OFS_RISE_DB, 32'h4);
    wr(`CT_OFS_FALL_DB, 32'h3);
    wr(`CT_OFS_RISE_PH, 32'h2);
    pair(20);
    wr(`CT_OFS_CTL, 32'hC0);
    wr(`CT_OFS_FALL_DB, 32'h2);
    pair(30);
    wr(`CT_OFS_CTL, 32'h0);
    wr(`CT_OFS_RISE_DB, 32'h0);
    wr(`CT_OFS_FALL_DB, 32'h0);
    wr(`CT_OFS_RISE_PH, 32'h0);
    pair(10);
    wr(`CT_OFS_RISE_BLK, 32'h5);
    ev(1'b1, 1'b1);
    ev(1'b0, 1'b0);
    idle(10);
    ev(1'b0, 1'b1);
    idle(10);
    wr(`CT_OFS_RISE_BLK, 32'h0);
    wr(`CT_OFS_FALL_BLK, 32'h5);
    ev(1'b1, 1'b1);
    idle(10);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    idle(10);
    ev(1'b1, 1'b1);
    idle(10);
    wr(`CT_OFS_FALL_BLK, 32'h0);
    wr(`CT_OFS_CTL, 32'h05);
    ev(1'b0, 1'b1);
    idle(10);
    v = rnd();
    wr(`CT_OFS_STEER, {24'h0, v[7:4], 4'h0});
    for (int m = 0; m < 8; m++) begin
      @(posedge sys_clk);
      mode <= 3'(m);
      @(posedge sys_clk);
      note(cnt, cnt + 6);
      idle(8);
    end
    idle(10);
    rd(`CT_OFS_STATUS, {24'h0, pinsOf(), comp, prim, 1'b0, prim}, 1'b0);
    check("pins left", 32'(pinQ.size()), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
